// >>> pkg/ssf_defs.svh
// Constants of the serial status flag block
//
// Contract
// - Conflict flag reads 1 after chip-select conflict
// - Four-wire master: chip-select low sets conflict
// - Four-wire slave: chip-select high mid-frame sets conflict
// - Overrun flag reads 1 after overrun
// - Reception ending with data-full set sets overrun
// - Overrun set blocks any new reception
// - Overrun set blocks master transmission start
// - Data-full flag shows unread received data
// - Reading receive data clears data-full flag
// - Transmit-end flag reads 1 when sending done
// - Transmit-empty flag reads 1 when nothing queued (reset loads 0; it first sets when a byte is loaded)
// - Unused status bits read 0, written 0
// - Mode bit 1 selects four-wire chip-select mode
// - Master/slave bit 1 selects master, internal clock
// - Receive interrupt enable gates full and overrun
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define SSF_ADDR_W 24
`define SSF_A_STATUS 24'h044f0c
`define SSF_A_MODE2 24'h044f0d
`define SSF_A_CTRL 24'h044f10
`define SSF_A_TXD 24'h044f11
`define SSF_A_RXD 24'h044f12
`define SSF_A_IRQST 24'h044f13
`define SSF_A_IRQMSK 24'h044f14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SSF_B_CE 0
`define SSF_B_RX_OVERRUN_FLAG 2
`define SSF_B_RX_DATA_FULL_FLAG 5
`define SSF_B_TX_COMPLETE_FLAG 6
`define SSF_B_TX_DATA_EMPTY_FLAG 7
`define SSF_B_FOURW 7
`define SSF_B_MASTER 0
`define SSF_B_RXEN 1
`define SSF_B_TXEN 2
`define SSF_B_RXIE 3
`define SSF_STATUS_USED 8'he5

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define SSF_RST_STATUS 8'h00
`define SSF_RST_CTRL 8'h00
`define SSF_FRAME_BITS 4'h8
`define SSF_IDLE_TX 8'hff
`define SSF_SYS_MHZ 50
`define SSF_SCK_DIV 4
`define SSF_HALF_CYCLES (`SSF_SCK_DIV / 2)

`endif

// >>> pkg/ssf_pkg.sv
// Types shared by the serial status flag block
package ssf_pkg;
	typedef enum logic {ST_IDLE, ST_SHIFT} ssf_state_t;
	typedef logic [7:0] ssf_byte_t;
endpackage

// >>> pkg/ssf_if.sv
// Link between flag control and shift engine
`timescale 1ns/1ps
interface ssf_if;
	logic start;
	ssf_pkg::ssf_byte_t tx_byte;
	logic master;
	logic run;
	logic busy;
	logic done;
	ssf_pkg::ssf_byte_t rx_byte;
	modport ctl (output start, output tx_byte, output master,
		output run, input busy, input done, input rx_byte);
	modport eng (input start, input tx_byte, input master,
		input run, output busy, output done, output rx_byte);
endinterface

// >>> rtl/ssf_shift.sv
// Eight-bit shift engine, master or slave clocked
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_shift #(
	parameter int HALF = `SSF_HALF_CYCLES
) (
	input wire logic clk, // System clock
	input wire logic rst, // Sync reset, high
	input wire logic sck_in, // Serial clock pin in
	input wire logic sdi_in, // Serial data pin in
	output logic sck_out, // Serial clock out
	output logic sck_oe, // Serial clock drive
	output logic sdo, // Serial data out
	ssf_if.eng lk // Control side
);
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic sck_s1_q, sck_s2_q, sck_s3_q, sdi_s1_q, sdi_s2_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
		end else begin
			sck_s1_q <= sck_in;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			sdi_s1_q <= sdi_in;
			sdi_s2_q <= sdi_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// Shift state
	// ---------------------------------------------------------------
	ssf_pkg::ssf_state_t st_q, st_d;
	logic [7:0] sh_q, sh_d, rx_q, rx_d, div_q, div_d;
	logic [3:0] bit_q, bit_d;
	logic sck_q, sck_d, done_q, done_d, rise, fall;
	logic smp_q, smp_d, smp;

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		rx_d = rx_q;
		div_d = div_q;
		bit_d = bit_q;
		sck_d = sck_q;
		done_d = 1'b0;
		smp_d = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		smp = 1'b0;
		unique case (st_q)
			ssf_pkg::ST_IDLE: begin
				sck_d = 1'b0;
				if (lk.start) begin
					sh_d = lk.tx_byte;
					bit_d = 4'h0;
					div_d = 8'h00;
					st_d = ssf_pkg::ST_SHIFT;
				end
			end
			ssf_pkg::ST_SHIFT: begin
				if (lk.master) begin
					if (div_q == 8'(HALF - 1)) begin
						div_d = 8'h00;
						sck_d = ~sck_q;
						rise = ~sck_q;
						fall = sck_q;
					end else begin
						div_d = div_q + 8'h01;
					end
					// Synced data lags our own edge: sample a cycle late
					smp = smp_q;
					smp_d = rise;
				end else begin
					rise = sck_s2_q & ~sck_s3_q;
					fall = ~sck_s2_q & sck_s3_q;
					smp = rise;
				end
				if (!lk.run) begin
					// Frame aborted, nothing delivered
					st_d = ssf_pkg::ST_IDLE;
				end else begin
					if (smp) begin
						rx_d = {rx_q[6:0], sdi_s2_q};
					end
					if (rise) begin
						bit_d = bit_q + 4'h1;
					end
					if (fall) begin
						sh_d = {sh_q[6:0], 1'b0};
						if (bit_q == `SSF_FRAME_BITS) begin
							done_d = 1'b1;
							st_d = ssf_pkg::ST_IDLE;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= ssf_pkg::ST_IDLE;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			div_q <= 8'h00;
			bit_q <= 4'h0;
			sck_q <= 1'b0;
			done_q <= 1'b0;
			smp_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			rx_q <= rx_d;
			div_q <= div_d;
			bit_q <= bit_d;
			sck_q <= sck_d;
			done_q <= done_d;
			smp_q <= smp_d;
		end
	end

	assign sck_out = sck_q;
	assign sck_oe = lk.master;
	assign sdo = sh_q[7];
	assign lk.busy = (st_q == ssf_pkg::ST_SHIFT);
	assign lk.done = done_q;
	assign lk.rx_byte = rx_q;
endmodule

// >>> rtl/ssf_top.sv
// Serial interface status flags with register port
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_top #(
	parameter int HALF = `SSF_HALF_CYCLES
) (
	input wire logic CLK_SYS, // System clock 50 MHz
	input wire logic SYS_RST, // Sync reset, high
	input wire logic [23:0] REG_ADDR, // Register address
	input wire logic [7:0] REG_WDATA, // Write data
	input wire logic REG_WR, // Write strobe
	input wire logic REG_RD, // Read strobe
	output logic [7:0] REG_RDATA, // Read data, next cycle
	input wire logic SCK_I, // Serial clock pin in
	output logic SCK_O, // Serial clock pin out
	output logic SCK_OE, // Serial clock drive enable
	input wire logic SDI, // Serial data in
	output logic SDO, // Serial data out
	input wire logic CHIP_SELECT_PIN, // Chip select in
	output logic IRQ // Interrupt, level high
);
	ssf_if lk();

	ssf_shift #(.HALF(HALF)) u_shift (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.sck_in(SCK_I),
		.sdi_in(SDI),
		.sck_out(SCK_O),
		.sck_oe(SCK_OE),
		.sdo(SDO),
		.lk(lk)
	);

	function automatic logic hit(input logic [23:0] a,
		input logic [23:0] ref_a);
		hit = (a == ref_a);
	endfunction

	logic wr_status, wr_mode2, wr_ctrl, wr_txd, wr_irqst, wr_irqmsk;
	logic rd_rxd;
	assign wr_status = REG_WR & hit(REG_ADDR, `SSF_A_STATUS);
	assign wr_mode2 = REG_WR & hit(REG_ADDR, `SSF_A_MODE2);
	assign wr_ctrl = REG_WR & hit(REG_ADDR, `SSF_A_CTRL);
	assign wr_txd = REG_WR & hit(REG_ADDR, `SSF_A_TXD);
	assign wr_irqst = REG_WR & hit(REG_ADDR, `SSF_A_IRQST);
	assign wr_irqmsk = REG_WR & hit(REG_ADDR, `SSF_A_IRQMSK);
	assign rd_rxd = REG_RD & hit(REG_ADDR, `SSF_A_RXD);

	// ---------------------------------------------------------------
	// Chip select synchroniser
	// ---------------------------------------------------------------
	logic cs_s1_q, cs_s2_q;
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= CHIP_SELECT_PIN;
			cs_s2_q <= cs_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// Configuration
	// ---------------------------------------------------------------
	logic four_wire_q, four_wire_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic master, rx_en, tx_en, rx_ie;

	always_comb begin
		four_wire_d = four_wire_q;
		ctrl_d = ctrl_q;
		if (wr_mode2) begin
			four_wire_d = REG_WDATA[`SSF_B_FOURW];
		end
		if (wr_ctrl) begin
			ctrl_d = REG_WDATA;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			four_wire_q <= 1'b0;
			ctrl_q <= `SSF_RST_CTRL;
		end else begin
			four_wire_q <= four_wire_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign master = ctrl_q[`SSF_B_MASTER];
	assign rx_en = ctrl_q[`SSF_B_RXEN];
	assign tx_en = ctrl_q[`SSF_B_TXEN];
	assign rx_ie = ctrl_q[`SSF_B_RXIE];

	// ---------------------------------------------------------------
	// Status flags and data holding registers
	// ---------------------------------------------------------------
	logic ce_q, ce_d, rx_overrun_flag_q, rx_overrun_flag_d, rx_data_full_flag_q, rx_data_full_flag_d;
	logic tx_complete_flag_q, tx_complete_flag_d, tx_data_empty_flag_q, tx_data_empty_flag_d;
	logic [7:0] tx_hold_q, tx_hold_d, rx_hold_q, rx_hold_d;
	logic cs_high, slave_blocked, go, load_tx;
	logic set_ce, set_rx_overrun_flag, set_rx_data_full_flag, set_tx_complete_flag, set_tx_data_empty_flag;

	// Flag write: a written 0 clears, a written 1 keeps
	function automatic logic wflag(input logic cur, input logic set,
		input logic clr);
		wflag = set | (cur & ~clr);
	endfunction

	always_comb begin
		cs_high = four_wire_q & cs_s2_q;
		// In four-wire mode, slave is deselected while chip select is high
		slave_blocked = ~master & cs_high;
		lk.master = master;
		lk.run = ~slave_blocked;
		go = 1'b0;
		if (!lk.busy && !lk.done && !rx_overrun_flag_q) begin
			if (master) begin
				go = tx_en & ~tx_data_empty_flag_q;
			end else begin
				go = (rx_en | tx_en) & ~slave_blocked;
			end
		end
		load_tx = go & tx_en & ~tx_data_empty_flag_q;
		lk.start = go;
		lk.tx_byte = load_tx ? tx_hold_q : `SSF_IDLE_TX;

		set_ce = 1'b0;
		if (four_wire_q && master && !cs_s2_q) begin
			set_ce = 1'b1;
		end
		if (four_wire_q && !master && cs_s2_q && lk.busy) begin
			set_ce = 1'b1;
		end
		set_rx_overrun_flag = lk.done & rx_en & rx_data_full_flag_q;
		set_rx_data_full_flag = lk.done & rx_en & ~rx_data_full_flag_q;
		set_tx_complete_flag = lk.done & tx_data_empty_flag_q;
		set_tx_data_empty_flag = load_tx;

		// writes of 1 leave flags alone; set beats clear
		ce_d = wflag(ce_q, set_ce,
			wr_status & ~REG_WDATA[`SSF_B_CE]);
		rx_overrun_flag_d = wflag(rx_overrun_flag_q, set_rx_overrun_flag,
			wr_status & ~REG_WDATA[`SSF_B_RX_OVERRUN_FLAG]);
		rx_data_full_flag_d = wflag(rx_data_full_flag_q, set_rx_data_full_flag, rd_rxd |
			(wr_status & ~REG_WDATA[`SSF_B_RX_DATA_FULL_FLAG]));
		tx_complete_flag_d = wflag(tx_complete_flag_q, set_tx_complete_flag, go |
			(wr_status & ~REG_WDATA[`SSF_B_TX_COMPLETE_FLAG]));
		tx_data_empty_flag_d = wflag(tx_data_empty_flag_q, set_tx_data_empty_flag, wr_txd |
			(wr_status & ~REG_WDATA[`SSF_B_TX_DATA_EMPTY_FLAG]));

		tx_hold_d = wr_txd ? REG_WDATA : tx_hold_q;
		// Overrun keeps the unread byte, new one is lost
		rx_hold_d = set_rx_data_full_flag ? lk.rx_byte : rx_hold_q;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ce_q <= 1'b0;
			rx_overrun_flag_q <= 1'b0;
			rx_data_full_flag_q <= 1'b0;
			tx_complete_flag_q <= 1'b0;
			tx_data_empty_flag_q <= 1'b0;
			tx_hold_q <= 8'h00;
			rx_hold_q <= 8'h00;
		end else begin
			ce_q <= ce_d;
			rx_overrun_flag_q <= rx_overrun_flag_d;
			rx_data_full_flag_q <= rx_data_full_flag_d;
			tx_complete_flag_q <= tx_complete_flag_d;
			tx_data_empty_flag_q <= tx_data_empty_flag_d;
			tx_hold_q <= tx_hold_d;
			rx_hold_q <= rx_hold_d;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status and mask
	// ---------------------------------------------------------------
	logic [7:0] irq_st_q, irq_st_d, irq_msk_q, irq_msk_d, ev;

	always_comb begin
		ev = 8'h00;
		ev[`SSF_B_CE] = set_ce & ~ce_q;
		ev[`SSF_B_RX_OVERRUN_FLAG] = set_rx_overrun_flag & rx_ie;
		ev[`SSF_B_RX_DATA_FULL_FLAG] = set_rx_data_full_flag & rx_ie;
		ev[`SSF_B_TX_COMPLETE_FLAG] = set_tx_complete_flag;
		ev[`SSF_B_TX_DATA_EMPTY_FLAG] = set_tx_data_empty_flag;
		// Write-one-to-clear; a new event in that cycle stays
		irq_st_d = ev | (irq_st_q & ~(wr_irqst ? REG_WDATA : 8'h00));
		irq_msk_d = wr_irqmsk ? REG_WDATA : irq_msk_q;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			irq_st_q <= 8'h00;
			irq_msk_q <= 8'h00;
		end else begin
			irq_st_q <= irq_st_d;
			irq_msk_q <= irq_msk_d;
		end
	end

	assign IRQ = |(irq_st_q & irq_msk_q);

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	logic [7:0] rdata_q, rdata_d, status;

	always_comb begin
		status = 8'h00;
		status[`SSF_B_CE] = ce_q;
		status[`SSF_B_RX_OVERRUN_FLAG] = rx_overrun_flag_q;
		status[`SSF_B_RX_DATA_FULL_FLAG] = rx_data_full_flag_q;
		status[`SSF_B_TX_COMPLETE_FLAG] = tx_complete_flag_q;
		status[`SSF_B_TX_DATA_EMPTY_FLAG] = tx_data_empty_flag_q;
		rdata_d = 8'h00;
		if (REG_RD) begin
			unique case (REG_ADDR)
				`SSF_A_STATUS: begin
					rdata_d = status & `SSF_STATUS_USED;
				end
				`SSF_A_MODE2: begin
					rdata_d = {four_wire_q, 7'h00};
				end
				`SSF_A_CTRL: begin
					rdata_d = ctrl_q;
				end
				`SSF_A_TXD: begin
					rdata_d = tx_hold_q;
				end
				`SSF_A_RXD: begin
					rdata_d = rx_hold_q;
				end
				`SSF_A_IRQST: begin
					rdata_d = irq_st_q;
				end
				`SSF_A_IRQMSK: begin
					rdata_d = irq_msk_q;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA = rdata_q;
endmodule

// >>> sim/ssf_top_assertions.sv
// Port-level checks of the serial status flag block
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_chk #(
	parameter int HALF = 2
) (
	input wire logic CLK_SYS, // Clock
	input wire logic SYS_RST, // Reset
	input wire logic [23:0] REG_ADDR, // Address
	input wire logic [7:0] REG_WDATA, // Write data
	input wire logic REG_WR, // Write strobe
	input wire logic REG_RD, // Read strobe
	input wire logic [7:0] REG_RDATA, // Read data
	input wire logic SCK_O, // Clock out
	input wire logic SCK_OE, // Clock drive
	input wire logic IRQ // Interrupt
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	logic [7:0] hi_q;
	logic [7:0] hi_d;
	// Length of the current high phase of the serial clock
	always_comb hi_d = SCK_O ? hi_q + 8'h01 : 8'h00;
	always_ff @(posedge CLK_SYS) hi_q <= SYS_RST ? 8'h00 : hi_d;
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_reset_quiet: assert property (
		$past(SYS_RST) |-> REG_RDATA == 8'h00 && !IRQ && !SCK_OE)
		else $error("outputs busy after reset");
	a_rdata_idle: assert property (
		!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data outside answer cycle");
	a_unused_zero: assert property (
		$past(REG_RD && REG_ADDR == `SSF_A_STATUS) |->
		(REG_RDATA & ~`SSF_STATUS_USED) == 8'h00)
		else $error("unused status bit set");
	a_oe_master: assert property (
		REG_WR && REG_ADDR == `SSF_A_CTRL |=>
		SCK_OE == $past(REG_WDATA[`SSF_B_MASTER]))
		else $error("clock drive not following master bit");
	a_sck_master: assert property (
		!SCK_OE && !SCK_O |=> !SCK_O)
		else $error("serial clock made as slave");
	a_sck_half: assert property (
		$fell(SCK_O) |-> hi_q == 8'(HALF))
		else $error("serial clock high phase wrong");
	a_irq_mask: assert property (
		REG_WR && REG_ADDR == `SSF_A_IRQMSK && REG_WDATA == 8'h00
		|=> !IRQ)
		else $error("interrupt with all masked");
	a_read_clear: assert property (
		(SCK_OE && !SCK_O) [*4] ##0 (REG_RD && REG_ADDR == `SSF_A_RXD)
		##2 (REG_RD && REG_ADDR == `SSF_A_STATUS) |=>
		!REG_RDATA[`SSF_B_RX_DATA_FULL_FLAG])
		else $error("full flag kept after data read");
	a_ovr_block: assert property (
		$past(REG_RD && REG_ADDR == `SSF_A_STATUS) &&
		REG_RDATA[`SSF_B_RX_OVERRUN_FLAG] && !SCK_O |=> !SCK_O [*2])
		else $error("frame started during overrun");
	c_overrun: cover property ($past(REG_RD) && REG_RDATA[`SSF_B_RX_OVERRUN_FLAG]);
	c_irq: cover property ($rose(IRQ));
	c_frame: cover property ($fell(SCK_O));
endmodule

// >>> sim/ssf_peer.sv
// Behavioural serial slave answering the block as master
`timescale 1ns/1ps
module ssf_peer (
	input wire logic sck, // Clock from block
	input wire logic mosi, // Data from block
	input wire logic sel, // Frame about to begin
	input wire logic [7:0] load, // Byte to return
	output logic miso, // Data to block
	output logic [7:0] got // Last byte taken
);
	int n;
	initial begin
		n = 0;
		miso = 1'b0;
		got = 8'h00;
	end
	// First bit must stand before the first rising edge
	always @(posedge sel) miso = load[7];
	always @(posedge sck) begin
		got = {got[6:0], mosi};
		n = n + 1;
	end
	// Out of frame the line flips, so no stale bit reads as good
	always @(negedge sck) begin
		if (n >= 8) begin
			n = 0;
			miso = ~miso;
		end else begin
			miso = load[7 - n];
		end
	end
endmodule

// >>> sim/test_sync_serial_status_flags.sv
// Self-checking bench of the serial status flag block
`timescale 1ns/1ps
`include "ssf_defs.svh"
module test_sync_serial_status_flags;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [23:0] reg_addr = 24'h000000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sck_drv = 1'b0;
	logic cs_n = 1'b1;
	logic peer_sel = 1'b0;
	logic [7:0] peer_load = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] peer_got;
	logic [7:0] d;
	logic [7:0] txb;
	logic sck_o;
	logic sck_oe;
	logic sck_pin;
	logic sdi;
	logic sdo;
	logic irq;
	int err_total = 0;
	int total_checks = 0;
	int rises = 0;
	int seed_v;
	initial forever #10 clk_sys = ~clk_sys;
	assign sck_pin = sck_oe ? sck_o : sck_drv;
	always @(posedge sck_o) rises++;
	ssf_top #(.HALF(2)) i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SCK_I(sck_pin),
		.SCK_O(sck_o), .SCK_OE(sck_oe), .SDI(sdi), .SDO(sdo),
		.CHIP_SELECT_PIN(cs_n), .IRQ(irq));
	ssf_peer i_peer (.sck(sck_o), .mosi(sdo), .sel(peer_sel),
		.load(peer_load), .miso(sdi), .got(peer_got));
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic close_out;
		if (err_total == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [23:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [23:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic rd_chk(input logic [23:0] a, input logic [7:0] m,
		input logic [7:0] e);
		rd(a, d);
		chk($sformatf("reg %h", a), e, d & m);
	endtask
	task automatic wait_bit(input int b);
		for (int j = 0; j < 60; j++) begin
			rd(`SSF_A_STATUS, d);
			if (d[b] === 1'b1)
				return;
		end
		err_total++;
		close_out();
	endtask
	task automatic arm(input logic [7:0] b);
		peer_sel <= 1'b0;
		peer_load <= b;
		@(posedge clk_sys);
		peer_sel <= 1'b1;
	endtask
	task automatic cs_pulse;
		cs_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		cs_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		seed_v = $urandom(4061);
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_chk(`SSF_A_STATUS, 8'hff, `SSF_RST_STATUS);
		rd_chk(`SSF_A_CTRL, 8'hff, `SSF_RST_CTRL);
		wr(24'h044f0e, 8'h5a);
		rd_chk(24'h044f0e, 8'hff, 8'h00);
		wr(`SSF_A_IRQMSK, 8'h20);
		for (int i = 0; i < 3; i++) begin
			txb = (i == 0) ? 8'h81 : 8'($urandom);
			arm((i == 0) ? 8'h7e : 8'($urandom));
			wr(`SSF_A_CTRL, 8'h0b);
			wr(`SSF_A_TXD, txb);
			rd_chk(`SSF_A_STATUS, 8'h80, 8'h00);
			wr(`SSF_A_CTRL, 8'h0f);
			rd_chk(`SSF_A_STATUS, 8'hc0, 8'h80);
			wait_bit(`SSF_B_RX_DATA_FULL_FLAG);
			rd_chk(`SSF_A_STATUS, 8'hff, 8'he0);
			chk("peer byte", txb, peer_got);
			rd_chk(`SSF_A_RXD, 8'hff, peer_load);
			rd_chk(`SSF_A_STATUS, 8'h20, 8'h00);
		end
		chk("irq", 8'h01, {7'h00, irq});
		wr(`SSF_A_IRQMSK, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
		wr(`SSF_A_IRQMSK, 8'h20);
		chk("irq", 8'h01, {7'h00, irq});
		wr(`SSF_A_IRQST, 8'h20);
		chk("irq", 8'h00, {7'h00, irq});
		arm(8'h3c);
		wr(`SSF_A_TXD, 8'hc3);
		wait_bit(`SSF_B_RX_DATA_FULL_FLAG);
		arm(8'ha5);
		wr(`SSF_A_TXD, 8'h18);
		wait_bit(`SSF_B_RX_OVERRUN_FLAG);
		rd_chk(`SSF_A_STATUS, 8'h24, 8'h24);
		arm(8'h69);
		wr(`SSF_A_TXD, 8'h5a);
		rises = 0;
		repeat (40) @(posedge clk_sys);
		chk("sck edges", 8'h00, 8'(rises));
		rd_chk(`SSF_A_STATUS, 8'h80, 8'h00);
		rd_chk(`SSF_A_RXD, 8'hff, 8'h3c);
		wr(`SSF_A_STATUS, 8'he1);
		wait_bit(`SSF_B_RX_DATA_FULL_FLAG);
		rd_chk(`SSF_A_STATUS, 8'h24, 8'h20);
		wr(`SSF_A_CTRL, 8'h01);
		cs_pulse();
		rd_chk(`SSF_A_STATUS, 8'h01, 8'h00);
		wr(`SSF_A_MODE2, 8'h80);
		cs_pulse();
		rd_chk(`SSF_A_STATUS, 8'h01, 8'h01);
		wr(`SSF_A_STATUS, 8'h00);
		rd_chk(`SSF_A_STATUS, 8'h01, 8'h00);
		wr(`SSF_A_CTRL, 8'h02);
		cs_n <= 1'b0;
		repeat (3) begin
			repeat (3) @(posedge clk_sys);
			sck_drv <= 1'b1;
			repeat (3) @(posedge clk_sys);
			sck_drv <= 1'b0;
		end
		cs_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd_chk(`SSF_A_STATUS, 8'h01, 8'h01);
		close_out();
	end
endmodule
bind ssf_top ssf_chk #(.HALF(HALF)) i_chk (.CLK_SYS(CLK_SYS),
	.SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.SCK_O(SCK_O), .SCK_OE(SCK_OE), .IRQ(IRQ));
